// ---- logic/sar_timing_pkg.sv ----
/*
 * Shared constants, types and decode functions for the converter sequencer.
 * Assumes a single 200 MHz core clock; all times are turned into cycles here.
 */
package sar_timing_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESULT_W = 16;
    localparam int CNT_W = 8;
    localparam int SH_CNT_W = 6;

    localparam int CONV_FAST_NS = 750;
    localparam int CONV_NORMAL_NS = 1000;
    localparam int CONV_LOWPWR_NS = 1250;
    // Input synchroniser, edge detect and settle cycles eat into the busy budget
    localparam int CONV_MARGIN_CYC = 8;
    localparam int EOC_TO_BUSY_NS = 20;
    localparam int SYNC_TO_BUSY_NS = 25;

    localparam int SCLK_PER_00_NS = 30;
    localparam int SCLK_PER_01_NS = 60;
    localparam int SCLK_PER_10_NS = 120;
    localparam int SCLK_PER_11_NS = 240;
    localparam int LEAD_00_NS = 4;
    localparam int LEAD_XX_NS = 20;
    localparam int LAG_00_NS = 3;
    localparam int LAG_01_NS = 60;
    localparam int LAG_10_NS = 140;
    localparam int LAG_11_NS = 300;

    localparam int CONV_FAST_CYC = CONV_FAST_NS * 1000 / CLK_PERIOD_PS - CONV_MARGIN_CYC;
    localparam int CONV_NORMAL_CYC = CONV_NORMAL_NS * 1000 / CLK_PERIOD_PS - CONV_MARGIN_CYC;
    localparam int CONV_LOWPWR_CYC = CONV_LOWPWR_NS * 1000 / CLK_PERIOD_PS - CONV_MARGIN_CYC;
    localparam int SETTLE_CYC = (EOC_TO_BUSY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TAIL_CYC = SYNC_TO_BUSY_NS * 1000 / CLK_PERIOD_PS;

    localparam logic [CNT_W-1:0] RESET_CNT = 8'h00;
    localparam logic [RESULT_W-1:0] RESET_RESULT = 16'h0000;

    typedef struct packed {
        logic fast;
        logic low_power;
        logic serial;
        logic read_after;
        logic [1:0] div_sel;
    } cfg_s;

    typedef struct packed {
        logic [SH_CNT_W-1:0] half;
        logic [SH_CNT_W-1:0] lead;
        logic [SH_CNT_W-1:0] lag;
    } sclk_timing_s;

    localparam cfg_s RESET_CFG = '0;

    function automatic logic [SH_CNT_W-1:0] ns_cyc(input int ns, input bit up);
        int c;
        c = up ? (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS : ns * 1000 / CLK_PERIOD_PS;
        return SH_CNT_W'(c);
    endfunction : ns_cyc

    function automatic logic [CNT_W-1:0] conv_cycles(input cfg_s c);
        if (c.fast && !c.low_power) begin
            return CNT_W'(CONV_FAST_CYC);
        end else if (c.low_power && !c.fast) begin
            return CNT_W'(CONV_LOWPWR_CYC);
        end
        return CNT_W'(CONV_NORMAL_CYC);
    endfunction : conv_cycles

    function automatic sclk_timing_s sclk_timing(input logic [1:0] code);
        sclk_timing_s t;
        unique case (code)
            2'h0: t = '{ns_cyc(SCLK_PER_00_NS / 2, 1'b0), ns_cyc(LEAD_00_NS, 1'b1),
                        ns_cyc(LAG_00_NS, 1'b1)};
            2'h1: t = '{ns_cyc(SCLK_PER_01_NS / 2, 1'b0), ns_cyc(LEAD_XX_NS, 1'b1),
                        ns_cyc(LAG_01_NS, 1'b1)};
            2'h2: t = '{ns_cyc(SCLK_PER_10_NS / 2, 1'b0), ns_cyc(LEAD_XX_NS, 1'b1),
                        ns_cyc(LAG_10_NS, 1'b1)};
            2'h3: t = '{ns_cyc(SCLK_PER_11_NS / 2, 1'b0), ns_cyc(LEAD_XX_NS, 1'b1),
                        ns_cyc(LAG_11_NS, 1'b1)};
        endcase
        return t;
    endfunction : sclk_timing
endpackage : sar_timing_pkg

// ---- logic/serial_shifter.sv ----
/*
 * Master serial transmitter: frame sync, divided serial clock, MSB-first data.
 * Assumes timings are held stable by the caller for the whole frame.
 */
`timescale 1ns/1ps
module serial_shifter
    import sar_timing_pkg::*;
#(
    parameter int WORD_W = RESULT_W
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic [WORD_W-1:0] i_word,
    input wire sclk_timing_s i_timing,
    output logic o_sync,
    output logic o_sclk,
    output logic o_sdo,
    output logic o_done
);
    typedef enum logic [3:0] {
        SH_IDLE = 4'b0001,
        SH_LEAD = 4'b0010,
        SH_SHIFT = 4'b0100,
        SH_LAG = 4'b1000
    } sh_state_e;

    sh_state_e state_reg, state_next;
    logic [SH_CNT_W-1:0] cnt_reg, cnt_next;
    logic [$clog2(WORD_W)-1:0] bit_reg, bit_next;
    logic [WORD_W-1:0] sh_reg, sh_next;
    logic sync_reg, sync_next, sclk_reg, sclk_next, done_reg, done_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        sync_next = sync_reg;
        sclk_next = sclk_reg;
        done_next = 1'b0;
        unique case (state_reg)
            SH_IDLE: begin
                if (i_start) begin
                    sync_next = 1'b1;
                    sh_next = i_word;
                    sclk_next = 1'b0;
                    bit_next = '0;
                    cnt_next = i_timing.lead - 1'b1;
                    state_next = SH_LEAD;
                end
            end
            SH_LEAD: begin
                if (cnt_reg == '0) begin
                    sclk_next = 1'b1;
                    cnt_next = i_timing.half - 1'b1;
                    state_next = SH_SHIFT;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            SH_SHIFT: begin
                if (cnt_reg != '0) begin
                    cnt_next = cnt_reg - 1'b1;
                end else if (!sclk_reg) begin
                    sclk_next = 1'b1;
                    cnt_next = i_timing.half - 1'b1;
                end else begin
                    sclk_next = 1'b0;
                    cnt_next = i_timing.half - 1'b1;
                    if (bit_reg == ($clog2(WORD_W))'(WORD_W - 1)) begin
                        cnt_next = i_timing.lag - 1'b1;
                        state_next = SH_LAG;
                    end else begin
                        sh_next = {sh_reg[WORD_W-2:0], 1'b0};
                        bit_next = bit_reg + 1'b1;
                    end
                end
            end
            SH_LAG: begin
                if (cnt_reg == '0) begin
                    sync_next = 1'b0;
                    done_next = 1'b1;
                    state_next = SH_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_reg <= SH_IDLE;
            cnt_reg <= '0;
            bit_reg <= '0;
            sh_reg <= '0;
            sync_reg <= 1'b0;
            sclk_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            sync_reg <= sync_next;
            sclk_reg <= sclk_next;
            done_reg <= done_next;
        end
    end

    assign o_sync = sync_reg;
    assign o_sclk = sclk_reg;
    assign o_sdo = sh_reg[WORD_W-1];
    assign o_done = done_reg;

    chk_sclk_high_min: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $rose(sclk_reg) && i_timing.half == 6'd3 |-> sclk_reg [*3] ##1 !sclk_reg)
        else $error("serial clock high phase wrong for code 00");
    chk_sclk_code11: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $rose(sclk_reg) && i_timing.half == 6'd24 && state_reg == SH_SHIFT
        |-> sclk_reg [*8] ##16 sclk_reg ##1 !sclk_reg)
        else $error("serial clock high phase wrong for code 11");
    chk_sync_lead: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $rose(sync_reg) && i_timing.lead == 6'd4 |-> !sclk_reg [*4] ##1 sclk_reg)
        else $error("sync lead to first clock edge wrong");
    chk_sync_lag: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $fell(sync_reg) && i_timing.lag == 6'h0C |-> !$past(sclk_reg, 12))
        else $error("sync dropped too soon after last edge");
    chk_msb_first: assert property (@(posedge i_core_clk) disable iff (i_srst)
        i_start && state_reg == SH_IDLE |=> sync_reg && o_sdo == $past(i_word[WORD_W-1]))
        else $error("first serial bit is not the MSB");
    cov_frame_done: cover property (@(posedge i_core_clk) disable iff (i_srst) done_reg);
endmodule : serial_shifter

// ---- logic/sar_conv_ctrl.sv ----
/*
 * Conversion sequencer and readout port of a 16-bit sampling converter.
 * Assumes the analog core presents a settled result on i_sar_result at end
 * of conversion; pins from the host are asynchronous and are synchronised.
 */
`timescale 1ns/1ps
module sar_conv_ctrl
    import sar_timing_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_convert_start_n,
    input wire logic i_chip_select_n,
    input wire logic i_fast_mode,
    input wire logic i_low_power,
    input wire logic i_serial_parallel_select,
    input wire logic i_read_after_convert,
    input wire logic [1:0] i_serial_clock_divider_select,
    input wire logic [RESULT_W-1:0] i_sar_result,
    output logic o_busy,
    output logic [RESULT_W-1:0] o_data,
    output logic o_data_oe,
    output logic o_sync,
    output logic o_sync_oe,
    output logic o_serial_clock,
    output logic o_serial_clock_oe,
    output logic o_serial_data_out,
    output logic o_serial_data_out_oe
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CONVERT = 5'b00010,
        ST_SETTLE = 5'b00100,
        ST_SERIAL = 5'b01000,
        ST_TAIL = 5'b10000
    } conv_state_e;

    localparam int SYNC_W = 8;

    logic [SYNC_W-1:0] pin_meta_reg, pin_sync_reg;
    logic start_prev_reg;
    cfg_s cfg;
    logic start_n_s, cs_n_s, start_fall;

    conv_state_e state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic [RESULT_W-1:0] result_reg, result_next;
    logic oe_par_reg, oe_par_next, oe_ser_reg, oe_ser_next;
    logic rac_reg, rac_next;
    logic eoc, sh_start, sh_done;
    sclk_timing_s timing;

    // Two-stage synchroniser for every host pin
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pin_meta_reg <= 8'hFF;
            pin_sync_reg <= 8'hFF;
            start_prev_reg <= 1'b1;
        end else begin
            pin_meta_reg <= {i_convert_start_n, i_chip_select_n, i_fast_mode, i_low_power,
                             i_serial_parallel_select, i_read_after_convert,
                             i_serial_clock_divider_select};
            pin_sync_reg <= pin_meta_reg;
            start_prev_reg <= start_n_s;
        end
    end

    assign start_n_s = pin_sync_reg[7];
    assign cs_n_s = pin_sync_reg[6];
    assign cfg = cfg_s'(pin_sync_reg[5:0]);
    assign start_fall = start_prev_reg && !start_n_s;
    // Next mode, so a frame launched from idle never uses the previous conversion's code
    assign timing = sclk_timing(rac_next ? cfg.div_sel : 2'h0);
    assign eoc = (state_reg == ST_CONVERT) && (cnt_reg == '0);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        result_next = result_reg;
        rac_next = rac_reg;
        sh_start = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_fall) begin
                    busy_next = 1'b1;
                    cnt_next = conv_cycles(cfg) - 1'b1;
                    rac_next = cfg.serial && cfg.read_after;
                    // Read during convert ships the previous result
                    sh_start = cfg.serial && !cfg.read_after;
                    state_next = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (cnt_reg == '0) begin
                    result_next = i_sar_result;
                    cnt_next = CNT_W'(SETTLE_CYC - 1);
                    state_next = ST_SETTLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_SETTLE: begin
                if (cnt_reg == '0) begin
                    if (rac_reg) begin
                        sh_start = 1'b1;
                        state_next = ST_SERIAL;
                    end else begin
                        busy_next = 1'b0;
                        state_next = ST_IDLE;
                    end
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_SERIAL: begin
                if (sh_done) begin
                    // Done rises in the same cycle that sync drops
                    cnt_next = CNT_W'(TAIL_CYC - 2);
                    state_next = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (cnt_reg == '0) begin
                    busy_next = 1'b0;
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase
        // Starts seen outside IDLE fall through untouched
        oe_par_next = !cfg.serial;
        oe_ser_next = cfg.serial && !cs_n_s;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= RESET_CNT;
            busy_reg <= 1'b0;
            result_reg <= RESET_RESULT;
            rac_reg <= 1'b0;
            oe_par_reg <= 1'b0;
            oe_ser_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            result_reg <= result_next;
            rac_reg <= rac_next;
            oe_par_reg <= oe_par_next;
            oe_ser_reg <= oe_ser_next;
        end
    end

    serial_shifter #(.WORD_W(RESULT_W)) u_shifter (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_start(sh_start),
        .i_word(state_reg == ST_IDLE ? result_reg : result_next),
        .i_timing(timing),
        .o_sync(o_sync),
        .o_sclk(o_serial_clock),
        .o_sdo(o_serial_data_out),
        .o_done(sh_done)
    );

    assign o_busy = busy_reg;
    assign o_data = result_reg;
    assign o_data_oe = oe_par_reg;
    assign o_sync_oe = oe_ser_reg;
    assign o_serial_clock_oe = oe_ser_reg;
    assign o_serial_data_out_oe = oe_ser_reg;

    // Busy length counter for width checks
    logic [10:0] busy_len_reg;
    always_ff @(posedge i_core_clk) begin
        if (i_srst || !busy_reg) begin
            busy_len_reg <= '0;
        end else begin
            busy_len_reg <= busy_len_reg + 1'b1;
        end
    end

    chk_busy_rise: assert property (@(posedge i_core_clk) disable iff (i_srst)
        start_fall && state_reg == ST_IDLE |=> busy_reg)
        else $error("busy did not rise after convert start");
    chk_busy_width: assert property (@(posedge i_core_clk) disable iff (i_srst)
        busy_reg && !rac_reg |-> busy_len_reg < 11'd248)
        else $error("busy held too long outside read after convert");
    chk_eoc_lead: assert property (@(posedge i_core_clk) disable iff (i_srst)
        eoc |=> busy_reg [*4])
        else $error("busy fell too soon after end of conversion");
    chk_data_valid: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $fell(busy_reg) && !rac_reg |-> $stable(result_reg) && $past(eoc, 5))
        else $error("data not settled before busy fell");
    chk_ignore_start: assert property (@(posedge i_core_clk) disable iff (i_srst)
        start_fall && state_reg == ST_CONVERT && !eoc |=> state_reg == ST_CONVERT
        && $stable(result_reg))
        else $error("convert start during busy was not ignored");
    chk_cs_enable: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !cs_n_s && cfg.serial |=> oe_ser_reg)
        else $error("serial outputs not enabled by chip select");
    chk_cs_release: assert property (@(posedge i_core_clk) disable iff (i_srst)
        cs_n_s |=> !oe_ser_reg)
        else $error("serial outputs not released by chip select");
    chk_sync_before_busy: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $fell(o_sync) && rac_reg |-> busy_reg [*5] ##1 !busy_reg)
        else $error("busy did not follow sync drop by 25 ns");
    chk_rac_busy_max: assert property (@(posedge i_core_clk) disable iff (i_srst)
        busy_reg && rac_reg |-> busy_len_reg < 11'd1150)
        else $error("read after convert busy too long");

    cov_parallel: cover property (@(posedge i_core_clk) $fell(busy_reg) && oe_par_reg);
    cov_rdc: cover property (@(posedge i_core_clk) sh_start && !rac_reg);
    cov_rac: cover property (@(posedge i_core_clk) $fell(busy_reg) && rac_reg);
endmodule : sar_conv_ctrl

// ---- bench/host_model.sv ----
/* Host side of the converter: pulses convert start on request and shifts in
   the serial frame. Assumes the core clock and the device's registered pins. */
`timescale 1ns/1ps
module host_model
    import sar_timing_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_go,
    input wire logic i_sync,
    input wire logic i_serial_clock,
    input wire logic i_serial_data_out,
    output logic o_convert_start_n,
    output logic [RESULT_W-1:0] o_word,
    output logic [4:0] o_bits
);
    logic sclk_d = 1'b0;
    logic sync_d = 1'b0;
    initial o_convert_start_n = 1'b1;
    initial o_word = '0;
    initial o_bits = '0;
    // Pulse of two cycles meets the minimum start width
    always @(posedge i_core_clk) begin
        if (i_go) begin
            #1 o_convert_start_n = 1'b0;
            repeat (2) @(posedge i_core_clk);
            #1 o_convert_start_n = 1'b1;
        end
    end
    // Sample data on each rising serial clock while the frame is open
    always @(posedge i_core_clk) begin
        sclk_d <= i_serial_clock;
        sync_d <= i_sync;
        if (i_sync && !sync_d) begin
            o_bits <= '0;
        end else if (i_sync && i_serial_clock && !sclk_d && o_bits < 5'h10) begin
            o_word <= {o_word[RESULT_W-2:0], i_serial_data_out};
            o_bits <= o_bits + 5'h01;
        end
    end
endmodule : host_model

// ---- bench/sar_conv_ctrl_tb.sv ----
/* Self-checking bench for sar_conv_ctrl: every mode, parallel and master serial
   readout. Assumes host_model as far side and a 200 MHz core clock. */
`timescale 1ns/1ps
module sar_conv_ctrl_tb
    import sar_timing_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, go = 1'b0, cs_n = 1'b1, fast = 1'b0, lp = 1'b0;
    logic ser = 1'b0, rac = 1'b0;
    logic [1:0] div = 2'h0;
    logic [RESULT_W-1:0] res = 16'h0000, word, data, p_data = 16'h0000;
    logic cnv_n, busy, d_oe, sync, sync_oe, sclk, sclk_oe, sdo, sdo_oe;
    logic p_cnv = 1'b1, p_busy = 1'b0, p_sync = 1'b0, p_sclk = 1'b0;
    logic [4:0] bits;
    int n_fail = 0, samples_checked = 0, cyc = 0, n_brise = 0;
    int t_fall, t_brise, t_bfall, t_dchg, t_srise, t_sfall, t_first, t_lrise, t_lfall;
    int per_min, per_max, hi_min;
    always #2.5 clk = ~clk;
    sar_conv_ctrl i_dut (.i_core_clk(clk), .i_srst(srst), .i_convert_start_n(cnv_n),
        .i_chip_select_n(cs_n), .i_fast_mode(fast), .i_low_power(lp),
        .i_serial_parallel_select(ser), .i_read_after_convert(rac),
        .i_serial_clock_divider_select(div), .i_sar_result(res), .o_busy(busy),
        .o_data(data), .o_data_oe(d_oe), .o_sync(sync), .o_sync_oe(sync_oe),
        .o_serial_clock(sclk), .o_serial_clock_oe(sclk_oe), .o_serial_data_out(sdo),
        .o_serial_data_out_oe(sdo_oe));
    host_model i_host (.i_core_clk(clk), .i_go(go), .i_sync(sync), .i_serial_clock(sclk),
        .i_serial_data_out(sdo), .o_convert_start_n(cnv_n), .o_word(word), .o_bits(bits));
    // Edge time stamps, in cycles
    always @(posedge clk) begin
        cyc++;
        if (p_cnv && !cnv_n) t_fall = cyc;
        if (!p_busy && busy) n_brise++;
        if (!p_busy && busy) t_brise = cyc;
        if (p_busy && !busy) t_bfall = cyc;
        if (p_data !== data) t_dchg = cyc;
        if (!p_sync && sync) t_srise = cyc;
        if (p_sync && !sync) t_sfall = cyc;
        if (!p_sclk && sclk && sync) begin
            if (t_lrise != 0 && cyc - t_lrise < per_min) per_min = cyc - t_lrise;
            if (t_lrise != 0 && cyc - t_lrise > per_max) per_max = cyc - t_lrise;
            if (t_first == 0) t_first = cyc;
            t_lrise = cyc;
        end
        if (p_sclk && !sclk && sync) begin
            t_lfall = cyc;
            if (cyc - t_lrise < hi_min) hi_min = cyc - t_lrise;
        end
        p_cnv = cnv_n;
        p_busy = busy;
        p_data = data;
        p_sync = sync;
        p_sclk = sclk;
    end
    task automatic print_verdict;
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [RESULT_W-1:0] exp, got);
        samples_checked++;
        if (exp !== got) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_in(input string what, input int lo, hi, got);
        samples_checked++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_in
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wait_busy(input logic lvl);
        int t;
        t = 0;
        while (busy !== lvl && t < 3000) begin
            tick(1);
            t++;
        end
        if (t >= 3000) begin
            n_fail++;
            print_verdict();
        end
    endtask : wait_busy
    task automatic start;
        per_min = 999;
        per_max = 0;
        hi_min = 999;
        t_first = 0;
        t_lrise = 0;
        n_brise = 0;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        wait_busy(1'b1);
    endtask : start
    task automatic convert(input logic [RESULT_W-1:0] r);
        res = r;
        start();
        wait_busy(1'b0);
        tick(2);
        chk_in("busy rise", 1, 6, t_brise - t_fall);
        tick(300);
    endtask : convert
    task automatic par_modes;
        int lim[3] = '{150, 200, 250};
        for (int m = 0; m < 3; m++) begin
            fast = (m == 0);
            lp = (m == 2);
            convert(16'hA5C0 + 16'(m));
            chk_in("busy width", 1, lim[m], t_bfall - t_brise);
            chk_in("data lead", 4, 999, t_bfall - t_dchg);
            chk_in("data delay", 0, lim[m], t_dchg - t_fall);
            chk("data", 16'hA5C0 + 16'(m), data);
            chk("data oe", 16'h0001, 16'(d_oe));
        end
    endtask : par_modes
    task automatic hold_ignore;
        fast = 1'b0;
        res = 16'h3C5A;
        start();
        tick(40);
        go = 1'b1;
        tick(1);
        go = 1'b0;
        wait_busy(1'b0);
        res = 16'hFFFF;
        tick(60);
        chk_in("busy count", 1, 1, n_brise);
        chk_in("busy width", 1, 250, t_bfall - t_brise);
        chk("held data", 16'h3C5A, data);
        tick(300);
    endtask : hold_ignore
    task automatic ser_after;
        int plo[4] = '{5, 10, 20, 40};
        int phi[4] = '{8, 14, 28, 56};
        int lag[4] = '{1, 12, 28, 60};
        int blim[4] = '{300, 400, 600, 1050};
        ser = 1'b1;
        rac = 1'b1;
        cs_n = 1'b0;
        fast = 1'b1;
        lp = 1'b0;
        for (int d = 0; d < 4; d++) begin
            div = 2'(d);
            convert(16'h8E31 ^ 16'(d));
            chk("word", 16'h8E31 ^ 16'(d), word);
            chk("bits", 16'h0010, 16'(bits));
            chk_in("sclk period", plo[d], phi[d], per_min);
            chk_in("sclk period", plo[d], phi[d], per_max);
            chk_in("sync lead", d == 0 ? 1 : 4, 999, t_first - t_srise);
            chk_in("sync lag", lag[d], 999, t_sfall - t_lfall);
            chk_in("busy width", 1, blim[d], t_bfall - t_brise);
            chk_in("sync to busy", 1, 10, t_bfall - t_sfall);
            chk("oe", 16'h0007, 16'({sync_oe, sclk_oe, sdo_oe}));
            chk("data oe", 16'h0000, 16'(d_oe));
        end
        fast = 1'b0;
        convert(16'h0F0F);
        chk_in("busy width", 1, 1100, t_bfall - t_brise);
    endtask : ser_after
    task automatic ser_during;
        rac = 1'b0;
        fast = 1'b1;
        convert(16'h6D29);
        chk("word", 16'h0F0F, word);
        chk_in("sclk period", 5, 8, per_min);
        chk_in("sclk period", 5, 8, per_max);
        chk_in("sclk high", 3, 999, hi_min);
    endtask : ser_during
    task automatic cs_gate;
        cs_n = 1'b1;
        tick(4);
        chk("oe off", 16'h0000, 16'({sync_oe, sclk_oe, sdo_oe}));
        cs_n = 1'b0;
        tick(4);
        chk("oe on", 16'h0007, 16'({sync_oe, sclk_oe, sdo_oe}));
    endtask : cs_gate
    initial begin
        tick(4);
        srst = 1'b0;
        tick(4);
        par_modes();
        hold_ignore();
        ser_after();
        ser_during();
        cs_gate();
        print_verdict();
    end
endmodule : sar_conv_ctrl_tb
